// ### hw/cct_timer.sv
/*
 * Two-channel capture/compare timer with an APB register slave.
 * Assumes an APB master on pclk; channel pins are asynchronous and each
 * channel slice synchronises its own input.
 */
// The register offsets and register access over APB were decided locally.
module cct_timer #(
    parameter int CH_N = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cct_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel 0 pin
    input wire logic chan0_pin_in,
    output logic chan0_pin_out,
    output logic chan0_pin_oe,
    // Channel 1 pin
    input wire logic chan1_pin_in,
    output logic chan1_pin_out,
    output logic chan1_pin_oe,
    // Interrupt request
    output logic irq
);
    import cct_pkg::*;

    typedef struct packed {
        logic [PSC_W-1:0] psc;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] modv;
        logic ovf;
        logic ovf_ie;
        logic halt;
        logic [PS_W-1:0] ps;
        cct_chsc_t [1:0] ch;
        logic cnt_new;
        logic wrap;
        logic act_sel;
        logic last_wr;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
    } cct_top_st_t;

    cct_top_st_t q;
    cct_top_st_t d;
    logic [CH_N-1:0] pin_in_w;
    logic [CH_N-1:0] pin_out_w;
    logic [CH_N-1:0] pin_oe_w;
    logic [CH_N-1:0] ev_w;
    logic [CH_N-1:0] val_we;
    logic [CNT_W-1:0] val_w [CH_N];
    logic linked;
    logic acc;
    logic wr;
    logic tick;
    logic [2:0] wsel;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [2:0] cct_decode(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_TIMER_SC: cct_decode = SEL_TIMER_SC;
            OFS_COUNT: cct_decode = SEL_COUNT;
            OFS_MODULO: cct_decode = SEL_MODULO;
            OFS_CH0_SC: cct_decode = SEL_CH0_SC;
            OFS_CH0_VAL: cct_decode = SEL_CH0_VAL;
            OFS_CH1_SC: cct_decode = SEL_CH1_SC;
            OFS_CH1_VAL: cct_decode = SEL_CH1_VAL;
            default: cct_decode = SEL_NONE;
        endcase
    endfunction : cct_decode

    // Divide by 2**ps; select 7 falls back to the slowest rate.
    function automatic logic [PSC_W-1:0] cct_psc_mask(input logic [PS_W-1:0] ps);
        logic [PS_W-1:0] s;
        s = (ps > PS_MAX) ? PS_MAX : ps;
        cct_psc_mask = PSC_W'((7'h01 << s) - 7'h01);
    endfunction : cct_psc_mask

    // ************************************************************
    // Channel slices
    // ************************************************************
    assign pin_in_w = {chan1_pin_in, chan0_pin_in};
    assign linked = q.ch[0].mode_sel_hi;

    cct_chan_if chif[CH_N] ();

    generate
        for (genvar i = 0; i < CH_N; i++) begin : g_ch
            assign chif[i].count = q.cnt;
            assign chif[i].cnt_new = q.cnt_new;
            assign chif[i].wrap = q.wrap;
            assign chif[i].cfg = q.ch[i];
            assign chif[i].released = (i != 0) && linked;
            assign chif[i].val_we = val_we[i];
            assign chif[i].wdata = pwdata[CNT_W-1:0];
            assign val_w[i] = chif[i].value;
            assign ev_w[i] = chif[i].event_hit;
            assign pin_out_w[i] = chif[i].pin_out;
            assign pin_oe_w[i] = chif[i].pin_oe;
            cct_channel u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(pin_in_w[i]),
                .bus(chif[i])
            );
        end
    endgenerate

    // A linked pair drives channel 0 from whichever value was written last before the latest wrap.
    assign chif[0].cmp_val = (linked && q.act_sel) ? val_w[1] : val_w[0];
    assign chif[1].cmp_val = val_w[1];

    // ************************************************************
    // Bus decode
    // ************************************************************
    assign acc = psel && penable && q.pready;
    assign wr = acc && pwrite;
    assign wsel = cct_decode(paddr);
    assign val_we[0] = wr && wsel == SEL_CH0_VAL;
    assign val_we[1] = wr && wsel == SEL_CH1_VAL;
    assign tick = !q.halt && (q.psc & cct_psc_mask(q.ps)) == cct_psc_mask(q.ps);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d = q;
        d.cnt_new = 1'b0;
        d.wrap = 1'b0;

        // Register writes; flag clears come first so that a set wins.
        if (wr) begin
            case (wsel)
                SEL_TIMER_SC: begin
                    d.ovf = q.ovf && !pwdata[TSC_OVF];
                    d.ovf_ie = pwdata[TSC_OVF_IE];
                    d.halt = pwdata[TSC_HALT];
                    d.ps = pwdata[TSC_PS_LSB +: PS_W];
                end
                SEL_MODULO: d.modv = pwdata[CNT_W-1:0];
                SEL_CH0_SC: begin
                    d.ch[0] = pwdata[CSC_LSB +: CSC_W];
                    d.ch[0].flag = q.ch[0].flag && !pwdata[CSC_FLAG];
                end
                SEL_CH1_SC: begin
                    d.ch[1] = pwdata[CSC_LSB +: CSC_W];
                    d.ch[1].flag = q.ch[1].flag && !pwdata[CSC_FLAG];
                end
                SEL_CH0_VAL: d.last_wr = 1'b0;
                SEL_CH1_VAL: d.last_wr = 1'b1;
                default: d.ovf = d.ovf;
            endcase
        end

        // Prescaler and counter; both freeze while halted.
        if (!q.halt) begin
            d.psc = q.psc + 6'h01;
        end
        if (tick) begin
            d.cnt_new = 1'b1;
            if (q.cnt == q.modv) begin
                d.cnt = COUNT_RST;
                d.wrap = 1'b1;
                d.ovf = 1'b1;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
        if (wr && wsel == SEL_TIMER_SC && pwdata[TSC_CLR]) begin
            d.cnt = COUNT_RST;
            d.psc = '0;
            d.cnt_new = 1'b0;
            d.wrap = 1'b0;
        end

        // Buffered pairing swaps the driving register only at a wrap.
        if (q.wrap) begin
            d.act_sel = q.last_wr;
        end
        if (!linked) begin
            d.act_sel = 1'b0;
            d.last_wr = 1'b0;
        end

        for (int i = 0; i < CH_N; i++) begin
            if (ev_w[i]) begin
                d.ch[i].flag = 1'b1;
            end
        end

        // Interrupt request from enabled flags.
        d.irq = (d.ovf && d.ovf_ie)
            || (d.ch[0].flag && d.ch[0].irq_en)
            || (d.ch[1].flag && d.ch[1].irq_en);

        // APB: data and response are captured in the setup cycle.
        d.pready = psel && !penable;
        d.pslverr = 1'b0;
        if (psel && !penable) begin
            d.pslverr = cct_decode(paddr) == SEL_NONE;
            case (cct_decode(paddr))
                SEL_TIMER_SC: d.prdata = {24'h0, q.ovf, q.ovf_ie, q.halt, 2'h0, q.ps};
                SEL_COUNT: d.prdata = {16'h0, q.cnt};
                SEL_MODULO: d.prdata = {16'h0, q.modv};
                SEL_CH0_SC: d.prdata = {24'h0, q.ch[0], 1'b0};
                SEL_CH0_VAL: d.prdata = {16'h0, val_w[0]};
                SEL_CH1_SC: d.prdata = {24'h0, q.ch[1], 1'b0};
                SEL_CH1_VAL: d.prdata = {16'h0, val_w[1]};
                default: d.prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.modv <= MODULO_RST;
            q.ps <= PS_RST;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;
    assign chan0_pin_out = pin_out_w[0];
    assign chan0_pin_oe = pin_oe_w[0];
    assign chan1_pin_out = pin_out_w[1];
    assign chan1_pin_oe = pin_oe_w[1];

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_modulo_wrap: assert property (
        tick && q.cnt == q.modv && !wr |=> q.cnt == COUNT_RST && q.ovf && q.wrap)
        else $error("counter did not wrap at the modulo value");
    a_count_step: assert property (
        tick && q.cnt != q.modv && !wr |=> q.cnt == $past(q.cnt) + 16'h0001)
        else $error("counter did not advance by one on a tick");
    a_halt_hold: assert property (
        q.halt && !wr |=> $stable(q.cnt) && $stable(q.psc))
        else $error("counter moved while halted");
    a_clear_counter: assert property (
        wr && wsel == SEL_TIMER_SC && pwdata[TSC_CLR] |=> q.cnt == COUNT_RST && q.psc == '0)
        else $error("counter clear did not zero counter and prescaler");
    a_ps_rate: assert property (
        q.ps == 3'h1 && !q.halt && !wr ##1 !wr |-> tick != $past(tick))
        else $error("divide-by-two prescale did not alternate ticks");
    a_irq_gate: assert property (
        q.ch[0].flag && q.ch[0].irq_en ##1 q.ch[0].flag && q.ch[0].irq_en |-> irq)
        else $error("enabled channel flag did not raise the interrupt");
    a_irq_masked: assert property (
        !(q.ovf && q.ovf_ie) && !(q.ch[0].flag && q.ch[0].irq_en)
        && !(q.ch[1].flag && q.ch[1].irq_en) |-> !irq)
        else $error("interrupt raised with no enabled flag");
    a_buffer_swap: assert property (
        linked && q.wrap && !wr |=> q.act_sel == $past(q.last_wr))
        else $error("linked pair did not swap at the wrap");
    a_count_read: assert property (
        psel && !penable && !pwrite && cct_decode(paddr) == SEL_COUNT
        |=> prdata == {16'h0, $past(q.cnt)} && pready)
        else $error("counter read returned the wrong value");

endmodule : cct_timer

// ### hw/cct_pkg.sv
/*
 * Shared constants and types of the two-channel capture/compare timer:
 * APB register offsets, field positions, reset values and counter width.
 * Assumes a 32-bit APB bus with byte addresses and one register per word.
 */
// Function
// - Two channels, each set up alone as input capture or output compare.
// - A 16-bit up-counter runs free or wraps at the modulo limit.
// - Software may read the counter any time without disturbing it.
// - Counter ticks come from a prescaler with seven rates set by prescale_select.
// - A halt control stops counting; a reset control clears counter and prescaler.
// - Capture triggers on rising, falling or either edge per edge select.
// - An active capture edge copies the counter into the channel value.
// - Every qualifying edge captures, whether the flag is set or not.
// - The captured value lands two bus cycles after the pin event.
// - A later capture overwrites an earlier, unread one.
// - A set channel flag requests an interrupt only when enabled.
// - Reset leaves the channel value registers unchanged.
// - On a compare match the pin is set, cleared or toggled as configured.
// - A compare match sets the channel flag and so may interrupt.
// - With toggle_at_wrap set, a compare pin toggles at each counter wrap; a match at count 0 acts after the toggle.
// - A new unbuffered compare value acts at once; a passed value waits a period.
// - Capture and compare share one counter, so capture plus offset times outputs.
// - chan0_buffered_link pairs channels; last-written value drives pin 0 per wrap.
// - Mode select 0:1 is unbuffered compare, 1:0 buffered compare.
// - In compare mode edge/level 1:0 clears the pin, 1:1 sets it.
package cct_pkg;

    localparam int CNT_W = 16;
    localparam int PSC_W = 6;
    localparam int ADDR_W = 8;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_TIMER_SC = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MODULO = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CH0_SC = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CH0_VAL = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CH1_SC = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CH1_VAL = 8'h18;

    // Decoded register selectors.
    localparam logic [2:0] SEL_TIMER_SC = 3'h0;
    localparam logic [2:0] SEL_COUNT = 3'h1;
    localparam logic [2:0] SEL_MODULO = 3'h2;
    localparam logic [2:0] SEL_CH0_SC = 3'h3;
    localparam logic [2:0] SEL_CH0_VAL = 3'h4;
    localparam logic [2:0] SEL_CH1_SC = 3'h5;
    localparam logic [2:0] SEL_CH1_VAL = 3'h6;
    localparam logic [2:0] SEL_NONE = 3'h7;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TSC_OVF = 7;
    localparam int TSC_OVF_IE = 6;
    localparam int TSC_HALT = 5;
    localparam int TSC_CLR = 4;
    localparam int TSC_PS_LSB = 0;
    localparam int PS_W = 3;
    localparam int CSC_FLAG = 7;
    localparam int CSC_LSB = 1;
    localparam int CSC_W = 7;

    // ************************************************************
    // Reset values and prescaler limits
    // ************************************************************
    localparam logic [CNT_W-1:0] MODULO_RST = 16'hffff;
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [PS_W-1:0] PS_RST = 3'h0;
    localparam logic [PS_W-1:0] PS_MAX = 3'h6;

    // Channel status/control, bits 7..1 of its register.
    typedef struct packed {
        logic flag;
        logic irq_en;
        logic mode_sel_hi;
        logic mode_sel_lo;
        logic edge_level_sel_hi;
        logic edge_level_sel_lo;
        logic toggle_at_wrap;
    } cct_chsc_t;

endpackage : cct_pkg

// ### hw/cct_chan_if.sv
/*
 * Connection between the timer core and one channel slice.
 * Assumes both ends share pclk; no clocking block is used.
 */
interface cct_chan_if;
    import cct_pkg::*;
    logic [CNT_W-1:0] count;
    logic cnt_new;
    logic wrap;
    cct_chsc_t cfg;
    logic released;
    logic val_we;
    logic [CNT_W-1:0] wdata;
    logic [CNT_W-1:0] cmp_val;
    logic [CNT_W-1:0] value;
    logic event_hit;
    logic pin_out;
    logic pin_oe;

    modport core (
        output count, cnt_new, wrap, cfg, released, val_we, wdata, cmp_val,
        input value, event_hit, pin_out, pin_oe
    );
    modport chan (
        input count, cnt_new, wrap, cfg, released, val_we, wdata, cmp_val,
        output value, event_hit, pin_out, pin_oe
    );
endinterface : cct_chan_if

// ### hw/cct_channel.sv
/*
 * One capture/compare channel: pin synchroniser, edge detect, value
 * register, compare match and pin drive.
 * Assumes the core supplies the counter and a pulse for each new count.
 */
module cct_channel (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Channel pin input
    input wire logic pin_in,
    // Core side
    cct_chan_if.chan bus
);
    import cct_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic pin;
        logic oe;
    } cct_ch_st_t;

    cct_ch_st_t q;
    cct_ch_st_t d;
    logic [CNT_W-1:0] value_q;
    logic [1:0] mode;
    logic [1:0] els;
    logic in_cap;
    logic out_mode;
    logic rise;
    logic fall;
    logic edge_hit;
    logic match;

    assign mode = {bus.cfg.mode_sel_hi, bus.cfg.mode_sel_lo};
    assign els = {bus.cfg.edge_level_sel_hi, bus.cfg.edge_level_sel_lo};
    assign in_cap = !bus.released && mode == 2'h0 && els != 2'h0;
    assign out_mode = !bus.released && mode != 2'h0;
    assign rise = q.sync2 && !q.prev;
    assign fall = !q.sync2 && q.prev;
    assign edge_hit = in_cap && ((els[0] && rise) || (els[1] && fall));
    assign match = out_mode && bus.cnt_new && bus.count == bus.cmp_val;

    assign bus.value = value_q;
    assign bus.event_hit = edge_hit || match;
    assign bus.pin_out = q.pin;
    assign bus.pin_oe = q.oe;

    always_comb begin
        d = q;
        d.sync1 = pin_in;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        if (out_mode && bus.wrap && bus.cfg.toggle_at_wrap) begin
            d.pin = !q.pin;
        end
        if (match) begin
            case (els)
                2'h1: d.pin = !d.pin;
                2'h2: d.pin = 1'b0;
                2'h3: d.pin = 1'b1;
                default: d.pin = d.pin;
            endcase
        end
        d.oe = out_mode && (els != 2'h0 || bus.cfg.toggle_at_wrap);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // The value register has no reset so that a capture survives it.
    always_ff @(posedge pclk) begin
        if (edge_hit) begin
            value_q <= bus.count;
        end else if (bus.val_we) begin
            value_q <= bus.wdata;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pin_rise;
        in_cap && els == 2'h1 && !bus.val_we && $rose(pin_in);
    endsequence
    sequence s_pin_held;
        (pin_in && in_cap && els == 2'h1) [*3];
    endsequence
    a_capture_two_cycles: assert property (
        s_pin_rise ##0 s_pin_held |=> value_q == $past(bus.count))
        else $error("capture not written two cycles after the pin edge");
    a_edge_latch: assert property (edge_hit |=> value_q == $past(bus.count))
        else $error("qualifying edge did not latch the counter");
    a_compare_clear: assert property (
        match && els == 2'h2 |=> !q.pin)
        else $error("clear-on-compare left the pin high");
    a_compare_set: assert property (match && els == 2'h3 |=> q.pin)
        else $error("set-on-compare left the pin low");
    a_wrap_toggle: assert property (
        out_mode && bus.wrap && bus.cfg.toggle_at_wrap && !match |=> q.pin != $past(q.pin))
        else $error("pin did not toggle at counter wrap");
    a_release_pin: assert property (bus.released |=> !q.oe)
        else $error("released channel still drives its pin");

endmodule : cct_channel

// ### verif/cct_pin_model.sv
/* Model of the sources and loads on both channel pins.
 * Assumes the bench sets the source levels and reads the channel 1 edge count. */
module cct_pin_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Source levels, seen while the timer does not drive
    input wire logic [1:0] ext_lvl,
    // Timer drive
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    // Wire levels of both pins and edge count of channel 1
    output logic [1:0] pin_lvl,
    output int unsigned n_edge1
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev1_q;
    // The timer owns the wire while it drives, so the source never fights it.
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev1_q <= 1'b0;
            n_edge1 <= 0;
        end else begin
            prev1_q <= pin_lvl[1];
            if (pin_lvl[1] !== prev1_q) n_edge1 <= n_edge1 + 1;
        end
    end
endmodule : cct_pin_model

// ### verif/tb_top.sv
/* Self-checking bench of the capture/compare timer.
 * Assumes the timer answers APB with pready and the pin model sits on both pins. */
module tb_top;
    import cct_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [1:0] ext_lvl = 2'h0;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] pin_lvl;
    int unsigned n_edge1;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic last_err;
    logic [31:0] rv;
    logic [15:0] cb;

    cct_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan0_pin_in(pin_lvl[0]), .chan0_pin_out(pin_out[0]),
        .chan0_pin_oe(pin_oe[0]), .chan1_pin_in(pin_lvl[1]), .chan1_pin_out(pin_out[1]),
        .chan1_pin_oe(pin_oe[1]), .irq(irq));
    cct_pin_model pins (.pclk(pclk), .presetn(presetn), .ext_lvl(ext_lvl),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl), .n_edge1(n_edge1));

    always #2 pclk = ~pclk;
    // The whole run needs about 1700 cycles; the ceiling leaves ample margin.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            complete_run();
        end
    end

    task complete_run;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Entered and left just after a rising edge; one idle cycle ends each transfer.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends this wait if pready never rises; the master accepts wait states.
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        chk(32'(pready), 32'h0);
    endtask : xfer

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_regs;
        xfer(0, OFS_MODULO, 32'h0);
        chk(rv, {16'h0, MODULO_RST});
        xfer(1, 8'h1c, 32'h5a);
        xfer(0, 8'h1c, 32'h0);
        chk({rv[31:1], last_err}, 32'h1);
    endtask : t_regs

    task t_count;
        logic [15:0] a;
        int n;
        for (n = 0; n < 7; n++) begin
            xfer(1, OFS_TIMER_SC, 32'h10 | n);
            xfer(0, OFS_COUNT, 32'h0);
            a = rv[15:0];
            repeat (60) @(posedge pclk);
            xfer(0, OFS_COUNT, 32'h0);
            chk(32'((rv[15:0] - a) == (63 >> n) || (rv[15:0] - a) == (63 >> n) + 1), 1);
        end
        xfer(1, OFS_TIMER_SC, 32'h10);
        xfer(0, OFS_COUNT, 32'h0);
        a = rv[15:0];
        xfer(0, OFS_COUNT, 32'h0);
        chk(32'(rv[15:0] - a), 32'h3);
    endtask : t_count

    task t_halt;
        xfer(1, OFS_TIMER_SC, 32'h20);
        xfer(1, OFS_TIMER_SC, 32'h30);
        repeat (20) @(posedge pclk);
        xfer(0, OFS_COUNT, 32'h0);
        chk(rv, 32'h0);
        xfer(1, OFS_TIMER_SC, 32'h0);
        xfer(0, OFS_COUNT, 32'h0);
        chk(32'(rv > 0 && rv < 5), 1);
    endtask : t_halt

    task t_wrap;
        int i;
        xfer(1, OFS_MODULO, 32'h0f);
        xfer(1, OFS_TIMER_SC, 32'h50);
        for (i = 0; i < 6; i++) begin
            xfer(0, OFS_COUNT, 32'h0);
            chk(32'(rv <= 32'h0f), 1);
        end
        xfer(0, OFS_TIMER_SC, 32'h0);
        chk(32'({rv[TSC_OVF], irq}), 32'h3);
        xfer(1, OFS_TIMER_SC, 32'h60);
        xfer(1, OFS_TIMER_SC, 32'he0);
        chk(irq, 1'b0);
        xfer(1, OFS_TIMER_SC, 32'h0);
        repeat (40) @(posedge pclk);
        xfer(0, OFS_TIMER_SC, 32'h0);
        chk(32'({rv[TSC_OVF], irq}), 32'h2);
        xfer(1, OFS_MODULO, 32'hffff);
    endtask : t_wrap

    task t_capture;
        logic [15:0] ca;
        int es;
        for (es = 1; es < 4; es++) begin
            xfer(1, OFS_CH0_SC, 32'h40 | (es << 2));
            xfer(1, OFS_TIMER_SC, 32'h20);
            xfer(0, OFS_COUNT, 32'h0);
            ca = rv[15:0];
            ext_lvl[0] <= 1'b1;
            repeat (6) @(posedge pclk);
            xfer(1, OFS_TIMER_SC, 32'h0);
            repeat (20) @(posedge pclk);
            xfer(1, OFS_TIMER_SC, 32'h20);
            xfer(0, OFS_COUNT, 32'h0);
            cb = rv[15:0];
            ext_lvl[0] <= 1'b0;
            repeat (6) @(posedge pclk);
            xfer(0, OFS_CH0_VAL, 32'h0);
            chk(rv, {16'h0, (es == 1) ? ca : cb});
            xfer(0, OFS_CH0_SC, 32'h0);
            chk(32'({rv[CSC_FLAG], irq}), 32'h3);
            xfer(1, OFS_CH0_SC, 32'h80);
        end
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(0, OFS_CH0_VAL, 32'h0);
        chk(rv, {16'h0, cb});
    endtask : t_capture

    task t_compare;
        int unsigned e0;
        xfer(1, OFS_TIMER_SC, 32'h30);
        xfer(1, OFS_MODULO, 32'h3f);
        xfer(1, OFS_CH1_VAL, 32'h20);
        xfer(1, OFS_CH1_SC, 32'h1c);
        @(posedge pclk);
        chk(32'({pin_oe[1], pin_out[1]}), 32'h2);
        xfer(1, OFS_TIMER_SC, 32'h0);
        repeat (10) @(posedge pclk);
        chk(pin_out[1], 1'b0);
        repeat (30) @(posedge pclk);
        chk(pin_out[1], 1'b1);
        xfer(0, OFS_CH1_SC, 32'h0);
        chk(rv[CSC_FLAG], 1'b1);
        xfer(1, OFS_CH1_VAL, 32'h10);
        xfer(1, OFS_CH1_SC, 32'h98);
        repeat (64) @(posedge pclk);
        chk(pin_out[1], 1'b0);
        xfer(1, OFS_CH1_VAL, 32'h30);
        e0 = n_edge1;
        xfer(1, OFS_CH1_SC, 32'h12);
        repeat (640) @(posedge pclk);
        chk(32'(n_edge1 - e0 >= 9 && n_edge1 - e0 <= 11), 1);
        xfer(1, OFS_CH0_SC, 32'h22);
        repeat (70) @(posedge pclk);
        chk(32'(pin_oe), 32'h1);
    endtask : t_compare

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_count();
        t_halt();
        t_wrap();
        t_capture();
        t_compare();
        complete_run();
    end
endmodule : tb_top
